/* File: hw/mrm_map.svh */
`ifndef MRM_MAP_SVH
`define MRM_MAP_SVH
// Function
// [RULE1] Register locations 0000 to FFFF are looked up as the mapping key.
// [RULE2] Holding locations resolve to terminal, parameter, constant, feature or event source.
// [RULE3] String parameters expose only their configured byte length through registers.
// [RULE4] Parameter value on the bus is the value divided by the register scaling.
// [RULE5] Each mapped register keeps its own read and write permission, checked per access.
// [RULE6] Client writes to a watchdog register retrigger the timeout; delay is configured.
// [RULE7] A 32-bit REAL parameter takes two consecutive locations from its mapped one.
// [RULE8] Mapped events appear newest first, six consecutive locations per event.
// [RULE9] Event words 0..3 hold seconds/ms, hours/minutes, month/day, year as hex digits.
// [RULE10] Event word 4: MSB active flag, low bits severity 010 info, 011 warning, 100 fault.
// [RULE11] Event word 5 holds the application event code.
// [RULE12] Input registers are 16-bit read-only; writes never change a source.
// [RULE13] Input registers resolve only to parameter, constant or event sources.
// [RULE14] Holding locations below 20 are fixed or reserved; free mapping starts at 20.
// [RULE15] Holding location 2 is the control word, location 10 the status word.
// [RULE16] A register without its own permission allows all access.
// [RULE17] Denied or unmapped accesses answer with a Modbus exception instead of data.
// [RULE18] Client moves both halves of a REAL value in one transaction; here each request carries one 16-bit location, so the halves take two requests.

// register port offsets
`define MRM_CFG_IRQ_STAT  8'h00
`define MRM_CFG_IRQ_MASK  8'h01
`define MRM_CFG_WD_DELAY  8'h02
`define MRM_CFG_STATUS    8'h03
`define MRM_CFG_CTRL_WORD 8'h04
`define MRM_CFG_ENT_BASE  8'h40
// entry word select
`define MRM_ENT_W_CTL     2'h0
`define MRM_ENT_W_SCALE   2'h1
`define MRM_ENT_W_REF     2'h2
// interrupt status bits
`define MRM_IRQ_WD        0
`define MRM_IRQ_EXC       1
`define MRM_IRQ_FEAT      2
`define MRM_IRQ_W         3
// fixed holding locations
`define MRM_FREE_LOC      16'h0014
`define MRM_LOC_CTRL      16'h0002
`define MRM_LOC_STAT      16'h000A
// spans
`define MRM_EV_WORDS      16'h0006
`define MRM_REAL_WORDS    32'h0000_0002
// modbus exception codes
`define MRM_EXC_ILL_FUNC  8'h01
`define MRM_EXC_ILL_ADDR  8'h02
// timing
`define MRM_CLK_NS        40
`define MRM_MS_NS         1000000
`define MRM_MS_CYCLES     (`MRM_MS_NS / `MRM_CLK_NS)
`define MRM_WD_DELAY_RST  32'h0000_0000
`endif

/* File: hw/mrm_pkg.sv */
package mrm_pkg;
	typedef enum logic [2:0] {
		MRM_SRC_TERM  = 3'h0,
		MRM_SRC_PARAM = 3'h1,
		MRM_SRC_CONST = 3'h2,
		MRM_SRC_FEAT  = 3'h3,
		MRM_SRC_EVENT = 3'h4
	} mrm_src_t;

	typedef enum logic [1:0] {
		MRM_ST_IDLE = 2'h0,
		MRM_ST_LOOK = 2'h1,
		MRM_ST_ANS  = 2'h3
	} mrm_state_t;

	typedef struct packed {
		logic        valid;
		logic [5:0]  rsvd;
		logic        real_f;
		logic        wd;
		logic        perm_wr;
		logic        perm_rd;
		logic        perm_set;
		logic        input_space;
		mrm_src_t    src;
		logic [15:0] loc;
	} mrm_ctl_t;

	typedef struct packed {
		mrm_ctl_t    ctl;
		logic [15:0] len;
		logic [15:0] scale;
		logic [31:0] ref_val;
	} mrm_entry_t;

	typedef struct packed {
		logic        write;
		logic        input_space;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mrm_req_t;

	typedef struct packed {
		logic        exc;
		logic [7:0]  exc_code;
		logic [15:0] data;
	} mrm_rsp_t;

	typedef struct packed {
		logic [15:0] sec_ms;
		logic [15:0] hhmm;
		logic [15:0] mmdd;
		logic [15:0] year;
		logic        active;
		logic [2:0]  severity;
		logic [15:0] code;
	} mrm_event_t;
endpackage

/* File: hw/mrm_mapper.sv */
`timescale 1ns/100ps
`include "mrm_map.svh"

module mrm_mapper
	import mrm_pkg::*;
#(
	parameter int NMAP      = 8,
	parameter int MS_CYCLES = `MRM_MS_CYCLES
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// register port
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [31:0] cfg_wdata,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	output logic      [31:0] cfg_rdata,
	// modbus request and answer
	input  wire logic        req_valid,
	input  mrm_req_t         req,
	output logic             req_ready,
	output logic             rsp_valid,
	output mrm_rsp_t         rsp,
	// parameter store
	output logic      [31:0] param_sel,
	output logic      [7:0]  param_woff,
	input  wire logic [31:0] param_rdata,
	output logic             param_wr,
	output logic      [31:0] param_wdata,
	// option terminals and fixed words
	input  wire logic [15:0] term_in,
	output logic      [15:0] term_out,
	output logic      [15:0] ctrl_word,
	input  wire logic [15:0] status_word,
	// event log, index 0 is newest
	output logic      [15:0] evlog_sel,
	input  mrm_event_t       evlog_rec,
	// features, watchdog, interrupt
	output logic             feat_pulse,
	output logic      [15:0] feat_code,
	output logic             wd_expired,
	output logic             irq
);
	localparam int IW = (NMAP > 1) ? $clog2(NMAP) : 1;
	localparam int PW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

	function automatic logic [31:0] mrm_span(mrm_entry_t e);
		logic [31:0] s;
		s = 32'h0000_0001;
		if (e.ctl.src == MRM_SRC_EVENT)
			s = 32'(e.len) * 32'(`MRM_EV_WORDS); // RULE8
		else if (e.ctl.src == MRM_SRC_PARAM && e.ctl.real_f)
			s = `MRM_REAL_WORDS; // RULE7
		else if (e.ctl.src == MRM_SRC_PARAM && e.len != 16'h0000)
			s = (32'(e.len) + 32'h0000_0001) >> 1; // RULE3
		return s;
	endfunction

	function automatic logic [31:0] mrm_scale(logic [15:0] s);
		return (s == 16'h0000) ? 32'h0000_0001 : 32'(s);
	endfunction

	function automatic logic [15:0] mrm_ev_word(mrm_event_t e, logic [2:0] w);
		logic [15:0] v;
		v = 16'h0000;
		unique case (w)
			3'h0: v = e.sec_ms; // RULE9
			3'h1: v = e.hhmm;
			3'h2: v = e.mmdd;
			3'h3: v = e.year;
			3'h4: v = {e.active, 12'h000, e.severity}; // RULE10
			default: v = e.code; // RULE11
		endcase
		return v;
	endfunction

	mrm_state_t  state_r;
	mrm_req_t    req_r;
	mrm_entry_t  ent_r [NMAP];
	logic [`MRM_IRQ_W-1:0] irq_stat_r;
	logic [`MRM_IRQ_W-1:0] irq_mask_r;
	logic [`MRM_IRQ_W-1:0] irq_set;
	logic [31:0] wd_delay_r;
	logic [31:0] cfg_rdata_r;

	// lookup results
	logic        hit;
	logic [IW-1:0] hit_idx;
	logic [15:0] hit_off;
	logic        exc_nxt;
	logic [7:0]  code_nxt;
	logic [1:0]  fix_nxt;

	// answer stage
	logic [IW-1:0] idx_r;
	logic [15:0] off_r;
	logic        exc_r;
	logic [7:0]  code_r;
	logic [1:0]  fix_r;
	logic [2:0]  ev_word_r;
	mrm_entry_t  cur;
	logic [15:0] rdata;
	logic        wr_ok;
	logic        wd_kick;
	logic [31:0] quot;

	logic        rsp_valid_r;
	mrm_rsp_t    rsp_r;
	logic [31:0] param_sel_r;
	logic [7:0]  param_woff_r;
	logic        param_wr_r;
	logic [31:0] param_wdata_r;
	logic [15:0] term_out_r;
	logic [15:0] ctrl_word_r;
	logic [15:0] evlog_sel_r;
	logic        feat_pulse_r;
	logic [15:0] feat_code_r;

	logic          wd_run_r;
	logic          wd_expired_r;
	logic [PW-1:0] wd_pre_r;
	logic [31:0]   wd_ms_r;

	assign req_ready = (state_r == MRM_ST_IDLE);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r <= MRM_ST_IDLE;
		end else begin
			unique case (state_r)
				MRM_ST_IDLE: if (req_valid) state_r <= MRM_ST_LOOK;
				MRM_ST_LOOK: state_r <= MRM_ST_ANS;
				MRM_ST_ANS:  state_r <= MRM_ST_IDLE;
				default:     state_r <= MRM_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			req_r <= '0;
		else if (req_valid && req_ready)
			req_r <= req;
	end

	// first matching entry wins; overlapping spans are a configuration fault
	always_comb begin
		hit = 1'b0;
		hit_idx = '0;
		hit_off = 16'h0000;
		for (int i = 0; i < NMAP; i++) begin
			if (!hit && ent_r[i].ctl.valid
					&& ent_r[i].ctl.input_space == req_r.input_space
					&& (req_r.input_space || ent_r[i].ctl.loc >= `MRM_FREE_LOC) // RULE14
					&& req_r.addr >= ent_r[i].ctl.loc // RULE1
					&& 32'(req_r.addr - ent_r[i].ctl.loc) < mrm_span(ent_r[i])) begin
				hit = 1'b1;
				hit_idx = IW'(i);
				hit_off = req_r.addr - ent_r[i].ctl.loc;
			end
		end
	end

	always_comb begin
		exc_nxt = 1'b0;
		code_nxt = `MRM_EXC_ILL_ADDR;
		fix_nxt = 2'h0;
		if (!req_r.input_space && req_r.addr < `MRM_FREE_LOC) begin // RULE14
			if (req_r.addr == `MRM_LOC_CTRL) begin // RULE15
				fix_nxt = 2'h1;
			end else if (req_r.addr == `MRM_LOC_STAT) begin
				fix_nxt = 2'h2;
				if (req_r.write) begin
					exc_nxt = 1'b1;
					code_nxt = `MRM_EXC_ILL_FUNC;
				end
			end else begin
				exc_nxt = 1'b1;
			end
		end else if (!hit) begin
			exc_nxt = 1'b1; // RULE17
		end else if (req_r.input_space && (ent_r[hit_idx].ctl.src == MRM_SRC_TERM
				|| ent_r[hit_idx].ctl.src == MRM_SRC_FEAT)) begin
			exc_nxt = 1'b1; // RULE13
		end else if (req_r.write && (req_r.input_space // RULE12
				|| ent_r[hit_idx].ctl.src == MRM_SRC_CONST
				|| ent_r[hit_idx].ctl.src == MRM_SRC_EVENT)) begin
			exc_nxt = 1'b1;
			code_nxt = `MRM_EXC_ILL_FUNC;
		end else if (ent_r[hit_idx].ctl.perm_set // RULE16
				&& !(req_r.write ? ent_r[hit_idx].ctl.perm_wr
					: ent_r[hit_idx].ctl.perm_rd)) begin
			exc_nxt = 1'b1; // RULE5
			code_nxt = `MRM_EXC_ILL_FUNC;
		end
	end

	// lookup is registered so the parameter store sees a stable selector
	always_ff @(posedge core_clk) begin
		if (rst) begin
			idx_r <= '0;
			off_r <= 16'h0000;
			exc_r <= 1'b0;
			code_r <= 8'h00;
			fix_r <= 2'h0;
			ev_word_r <= 3'h0;
			param_sel_r <= 32'h0000_0000;
			param_woff_r <= 8'h00;
			evlog_sel_r <= 16'h0000;
		end else if (state_r == MRM_ST_LOOK) begin
			idx_r <= hit_idx;
			off_r <= hit_off;
			exc_r <= exc_nxt;
			code_r <= code_nxt;
			fix_r <= fix_nxt;
			ev_word_r <= 3'(hit_off % `MRM_EV_WORDS); // RULE8
			evlog_sel_r <= hit_off / `MRM_EV_WORDS;
			param_sel_r <= ent_r[hit_idx].ref_val;
			param_woff_r <= hit_off[7:0];
		end
	end

	assign cur = ent_r[idx_r];
	assign quot = param_rdata / mrm_scale(cur.scale); // RULE4
	assign wr_ok = (state_r == MRM_ST_ANS) && req_r.write && !exc_r;
	assign wd_kick = wr_ok && fix_r == 2'h0 && cur.ctl.wd; // RULE6

	always_comb begin
		rdata = 16'h0000;
		if (fix_r == 2'h1) begin
			rdata = ctrl_word_r;
		end else if (fix_r == 2'h2) begin
			rdata = status_word;
		end else begin
			unique case (cur.ctl.src)
				MRM_SRC_TERM:  rdata = term_in; // RULE2
				MRM_SRC_CONST: rdata = cur.ref_val[15:0];
				MRM_SRC_EVENT: rdata = mrm_ev_word(evlog_rec, ev_word_r);
				MRM_SRC_PARAM: begin
					if (cur.ctl.real_f)
						rdata = off_r[0] ? param_rdata[15:0] : param_rdata[31:16]; // RULE7
					else if (cur.len != 16'h0000) begin
						rdata = param_rdata[15:0];
						if (32'({off_r, 1'b1}) >= 32'(cur.len))
							rdata[7:0] = 8'h00; // RULE3
					end else
						rdata = quot[15:0];
				end
				default:       rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rsp_valid_r <= 1'b0;
			rsp_r <= '0;
		end else begin
			rsp_valid_r <= (state_r == MRM_ST_ANS);
			if (state_r == MRM_ST_ANS) begin
				rsp_r.exc <= exc_r; // RULE17
				rsp_r.exc_code <= exc_r ? code_r : 8'h00;
				rsp_r.data <= (exc_r || req_r.write) ? 16'h0000 : rdata;
			end
		end
	end

	// write effects land on the answer edge, only for accepted writes
	always_ff @(posedge core_clk) begin
		if (rst) begin
			param_wr_r <= 1'b0;
			param_wdata_r <= 32'h0000_0000;
			term_out_r <= 16'h0000;
			ctrl_word_r <= 16'h0000;
			feat_pulse_r <= 1'b0;
			feat_code_r <= 16'h0000;
		end else begin
			param_wr_r <= 1'b0;
			feat_pulse_r <= 1'b0;
			if (wr_ok && fix_r == 2'h1)
				ctrl_word_r <= req_r.wdata; // RULE15
			if (wr_ok && fix_r == 2'h0) begin
				unique case (cur.ctl.src)
					MRM_SRC_TERM: term_out_r <= req_r.wdata;
					MRM_SRC_FEAT: begin
						feat_pulse_r <= 1'b1;
						feat_code_r <= cur.ref_val[15:0];
					end
					MRM_SRC_PARAM: begin
						param_wr_r <= 1'b1;
						if (cur.ctl.real_f || cur.len != 16'h0000)
							param_wdata_r <= {16'h0000, req_r.wdata};
						else
							param_wdata_r <= 32'(req_r.wdata) * mrm_scale(cur.scale); // RULE4
					end
					default: param_wr_r <= 1'b0;
				endcase
			end
		end
	end

	// delay of zero keeps the watchdog idle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wd_run_r <= 1'b0;
			wd_expired_r <= 1'b0;
			wd_pre_r <= '0;
			wd_ms_r <= 32'h0000_0000;
		end else if (wd_kick) begin
			wd_run_r <= (wd_delay_r != 32'h0000_0000); // RULE6
			wd_expired_r <= 1'b0;
			wd_pre_r <= '0;
			wd_ms_r <= 32'h0000_0000;
		end else if (wd_run_r) begin
			if (wd_pre_r == PW'(MS_CYCLES - 1)) begin
				wd_pre_r <= '0;
				wd_ms_r <= wd_ms_r + 32'h0000_0001;
				if (wd_ms_r + 32'h0000_0001 >= wd_delay_r) begin
					wd_run_r <= 1'b0;
					wd_expired_r <= 1'b1;
				end
			end else begin
				wd_pre_r <= wd_pre_r + PW'(1);
			end
		end
	end

	assign irq_set[`MRM_IRQ_WD] = wd_run_r && !wd_kick && wd_pre_r == PW'(MS_CYCLES - 1)
		&& wd_ms_r + 32'h0000_0001 >= wd_delay_r;
	assign irq_set[`MRM_IRQ_EXC] = (state_r == MRM_ST_ANS) && exc_r;
	assign irq_set[`MRM_IRQ_FEAT] = wr_ok && fix_r == 2'h0 && cur.ctl.src == MRM_SRC_FEAT;

	// a new event beats a write-one-to-clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (rst)
			irq_stat_r <= '0;
		else if (cfg_wr && cfg_addr == `MRM_CFG_IRQ_STAT)
			irq_stat_r <= (irq_stat_r & ~cfg_wdata[`MRM_IRQ_W-1:0]) | irq_set;
		else
			irq_stat_r <= irq_stat_r | irq_set;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_mask_r <= '0;
			wd_delay_r <= `MRM_WD_DELAY_RST;
		end else if (cfg_wr) begin
			if (cfg_addr == `MRM_CFG_IRQ_MASK)
				irq_mask_r <= cfg_wdata[`MRM_IRQ_W-1:0];
			if (cfg_addr == `MRM_CFG_WD_DELAY)
				wd_delay_r <= cfg_wdata;
		end
	end

	// mapping table; entries start invalid so no mapped location answers until set up
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NMAP; i++)
				ent_r[i] <= '0;
		end else if (cfg_wr && cfg_addr >= `MRM_CFG_ENT_BASE) begin
			for (int i = 0; i < NMAP; i++) begin
				if (32'((cfg_addr - `MRM_CFG_ENT_BASE) >> 2) == 32'(i)) begin
					unique case (cfg_addr[1:0])
						`MRM_ENT_W_CTL:   ent_r[i].ctl <= mrm_ctl_t'(cfg_wdata);
						`MRM_ENT_W_SCALE: {ent_r[i].len, ent_r[i].scale} <= cfg_wdata;
						`MRM_ENT_W_REF:   ent_r[i].ref_val <= cfg_wdata;
						default:          ent_r[i].ref_val <= ent_r[i].ref_val;
					endcase
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_rdata_r <= 32'h0000_0000;
		end else if (cfg_rd) begin
			cfg_rdata_r <= 32'h0000_0000;
			if (cfg_addr == `MRM_CFG_IRQ_STAT)
				cfg_rdata_r <= 32'(irq_stat_r);
			if (cfg_addr == `MRM_CFG_IRQ_MASK)
				cfg_rdata_r <= 32'(irq_mask_r);
			if (cfg_addr == `MRM_CFG_WD_DELAY)
				cfg_rdata_r <= wd_delay_r;
			if (cfg_addr == `MRM_CFG_STATUS)
				cfg_rdata_r <= {28'h0000000, wd_expired_r, wd_run_r, state_r};
			if (cfg_addr == `MRM_CFG_CTRL_WORD)
				cfg_rdata_r <= {16'h0000, ctrl_word_r};
			for (int i = 0; i < NMAP; i++) begin
				if (cfg_addr >= `MRM_CFG_ENT_BASE
						&& 32'((cfg_addr - `MRM_CFG_ENT_BASE) >> 2) == 32'(i)) begin
					unique case (cfg_addr[1:0])
						`MRM_ENT_W_CTL:   cfg_rdata_r <= 32'(ent_r[i].ctl);
						`MRM_ENT_W_SCALE: cfg_rdata_r <= {ent_r[i].len, ent_r[i].scale};
						`MRM_ENT_W_REF:   cfg_rdata_r <= ent_r[i].ref_val;
						default:          cfg_rdata_r <= 32'h0000_0000;
					endcase
				end
			end
		end
	end

	assign cfg_rdata   = cfg_rdata_r;
	assign rsp_valid   = rsp_valid_r;
	assign rsp         = rsp_r;
	assign param_sel   = param_sel_r;
	assign param_woff  = param_woff_r;
	assign param_wr    = param_wr_r;
	assign param_wdata = param_wdata_r;
	assign term_out    = term_out_r;
	assign ctrl_word   = ctrl_word_r;
	assign evlog_sel   = evlog_sel_r;
	assign feat_pulse  = feat_pulse_r;
	assign feat_code   = feat_code_r;
	assign wd_expired  = wd_expired_r;
	assign irq         = |(irq_stat_r & irq_mask_r);
endmodule

/* File: sim/mrm_mapper_props.sv */
`timescale 1ns/100ps
module mrm_mapper_props
	import mrm_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// modbus request and answer
	input  wire logic        req_valid,
	input  mrm_req_t         req,
	input  wire logic        req_ready,
	input  wire logic        rsp_valid,
	input  mrm_rsp_t         rsp,
	// mapped outputs
	input  wire logic [15:0] ctrl_word,
	input  wire logic        param_wr,
	input  wire logic        feat_pulse
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic tk;
	logic hw;
	assign tk = req_valid && req_ready;
	assign hw = tk && req.write && !req.input_space;

	ans_delay_a: assert property (tk |-> ##3 rsp_valid)
		else $error("answer not three cycles after take");
	busy_win_a: assert property (tk |=> !req_ready [*2] ##1 req_ready)
		else $error("ready window wrong");
	rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer longer than one cycle");
	in_wr_exc_a: assert property (tk && req.write && req.input_space |->
		##3 rsp.exc && rsp.exc_code == 8'h01)
		else $error("input register write not refused");
	resv_exc_a: assert property (tk && !req.input_space && req.addr < 16'h0014 &&
		req.addr != 16'h0002 && req.addr != 16'h000A |->
		##3 rsp.exc && rsp.exc_code == 8'h02)
		else $error("reserved location not refused");
	ctrl_wr_a: assert property (hw && req.addr == 16'h0002 |->
		##3 !rsp.exc && ctrl_word == $past(req.wdata, 3))
		else $error("control word not written");
	stat_wr_a: assert property (hw && req.addr == 16'h000A |->
		##3 rsp.exc && rsp.exc_code == 8'h01)
		else $error("status word write not refused");
	pwr_ok_a: assert property (param_wr |-> rsp_valid && !rsp.exc)
		else $error("parameter written outside good answer");
	feat_ok_a: assert property (feat_pulse |-> rsp_valid && !rsp.exc)
		else $error("feature fired outside good answer");
	exc_data_a: assert property (rsp_valid && rsp.exc |-> rsp.data == 16'h0000)
		else $error("exception carries data");
	rd_quiet_a: assert property (tk && !req.write |-> ##3 !param_wr && !feat_pulse)
		else $error("read caused a side effect");
endmodule

/* File: sim/mrm_client_model.sv */
`timescale 1ns/100ps
module mrm_client_model
	import mrm_pkg::*;
(
	// clock
	input  wire logic core_clk,
	// answer side
	input  wire logic req_ready,
	input  wire logic rsp_valid,
	input  mrm_rsp_t  rsp,
	// request side
	output logic      req_valid,
	output mrm_req_t  req
);
	initial begin
		req_valid = 1'b0;
		req = '0;
	end
	// one request outstanding; payload is scrambled once released
	task automatic xfer(input logic w, input logic inp, input logic [15:0] a,
		input logic [15:0] d, output mrm_rsp_t r, output logic ok);
		logic tk;
		int   n;
		ok = 1'b0;
		r = '0;
		n = 0;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= {w, inp, a, d};
		do begin
			#1 tk = req_ready;
			@(posedge core_clk);
			n++;
		end while (!tk && n < 8);
		req_valid <= 1'b0;
		req <= {~w, ~inp, ~a, ~d};
		for (n = 0; n < 8 && !ok; n++) begin
			@(posedge core_clk);
			#1 if (rsp_valid) begin
				ok = 1'b1;
				r = rsp;
			end
		end
	endtask
endmodule

/* File: sim/tb_mrm_mapper.sv */
`timescale 1ns/100ps
module tb_mrm_mapper
	import mrm_pkg::*;
;
	localparam int MSC = 4;
	logic        core_clk, rst, cfg_wr, cfg_rd, req_valid, req_ready, rsp_valid;
	logic        param_wr, feat_pulse, wd_expired, irq, ok;
	logic [7:0]  cfg_addr, param_woff;
	logic [31:0] cfg_wdata, cfg_rdata, param_sel, param_rdata, param_wdata, last_pw;
	logic [15:0] term_in, term_out, ctrl_word, status_word, evlog_sel, feat_code, fc;
	mrm_req_t    req;
	mrm_rsp_t    rsp, r;
	mrm_event_t  evlog_rec;
	int          n_fail, cmp_count, cyc;

	mrm_mapper #(.NMAP(8), .MS_CYCLES(MSC)) uut (.core_clk(core_clk), .rst(rst),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_rdata(cfg_rdata), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp(rsp), .param_sel(param_sel), .param_woff(param_woff),
		.param_rdata(param_rdata), .param_wr(param_wr), .param_wdata(param_wdata),
		.term_in(term_in), .term_out(term_out), .ctrl_word(ctrl_word),
		.status_word(status_word), .evlog_sel(evlog_sel), .evlog_rec(evlog_rec),
		.feat_pulse(feat_pulse), .feat_code(feat_code), .wd_expired(wd_expired), .irq(irq));
	mrm_client_model cli (.core_clk(core_clk), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp(rsp), .req_valid(req_valid), .req(req));

	always #20 core_clk = ~core_clk;
	// parameter store: 1 REAL, 2 integer 400, 3 string "ABCD"
	always_comb begin
		case (param_sel[2:0])
			3'h1: param_rdata = 32'h4049_0FDB;
			3'h2: param_rdata = 32'h0000_0190;
			3'h3: param_rdata = param_woff[0] ? 32'h0000_4344 : 32'h0000_4142;
			default: param_rdata = 32'h0000_0000;
		endcase
	end
	// event log: odd entries active, severity 010 on even and 011 on odd entries
	assign evlog_rec = {16'h1000 + evlog_sel, 16'h2000 + evlog_sel, 16'h3000 + evlog_sel,
		16'h2024, evlog_sel[0], 3'h2 + {2'h0, evlog_sel[0]}, 16'hC000 + evlog_sel};
	always @(posedge core_clk) begin
		if (param_wr)
			last_pw <= param_wdata;
		if (feat_pulse)
			fc <= feat_code;
		cyc++;
		if (cyc > 3000) begin
			n_fail++;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cw(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge core_clk);
		cfg_wr <= 1'b0;
	endtask
	task automatic cr(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge core_clk);
		cfg_rd <= 1'b1;
		cfg_addr <= a;
		@(posedge core_clk);
		cfg_rd <= 1'b0;
		#1 chk(nm, e, cfg_rdata);
	endtask
	// ex: {exc, code}; answer and completion compared together
	task automatic mb(input logic w, input logic inp, input logic [15:0] a, input logic [15:0] d,
		input logic [8:0] ex, input logic [15:0] ed, input string nm);
		cli.xfer(w, inp, a, d, r, ok);
		chk(nm, {6'h00, 1'b1, ex, ed}, {6'h00, ok, r});
	endtask
	function automatic logic [31:0] ent(logic [5:0] f, mrm_src_t s, logic [15:0] l);
		return {1'b1, 6'h00, f, s, l};
	endfunction
	task automatic map(input int i, input logic [31:0] c, input logic [31:0] w1, input logic [31:0] w2);
		cw(8'h40 + 8'(4 * i), c);
		cw(8'h41 + 8'(4 * i), w1);
		cw(8'h42 + 8'(4 * i), w2);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		{n_fail, cmp_count, cyc} = '0;
		{core_clk, cfg_wr, cfg_rd, cfg_addr, cfg_wdata, last_pw, fc} = '0;
		rst = 1'b1;
		term_in = 16'hA55A;
		status_word = 16'h0BEE;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		cr(8'h01, 32'h0, "mask reset");
		cr(8'h02, 32'h0, "delay reset");
		mb(0, 0, 16'h0014, 0, 9'h102, 16'h0, "unmapped after reset");
		map(0, ent(6'b110000, MRM_SRC_PARAM, 16'h0014), 32'h1, 32'h1);
		map(1, ent(6'b000000, MRM_SRC_PARAM, 16'h001E), 32'h4, 32'h2);
		map(2, ent(6'b000110, MRM_SRC_CONST, 16'h0028), 32'h0, 32'h1234);
		map(3, ent(6'b000000, MRM_SRC_EVENT, 16'h0032), 32'h0002_0000, 32'h0);
		map(4, ent(6'b000000, MRM_SRC_PARAM, 16'h0046), 32'h0003_0001, 32'h3);
		map(5, ent(6'b000000, MRM_SRC_FEAT, 16'h0050), 32'h0, 32'h9);
		map(6, ent(6'b000001, MRM_SRC_PARAM, 16'h0005), 32'h1, 32'h2);
		map(7, ent(6'b000000, MRM_SRC_TERM, 16'h0064), 32'h0, 32'h0);
		cr(8'h48, ent(6'b000110, MRM_SRC_CONST, 16'h0028), "entry readback");
		cr(8'h10, 32'h0, "unmapped cfg");
		mb(0, 0, 16'h0014, 0, 9'h0, 16'h4049, "real high");
		mb(0, 0, 16'h0015, 0, 9'h0, 16'h0FDB, "real low");
		mb(0, 0, 16'h001E, 0, 9'h0, 16'd100, "scaled read");
		mb(1, 0, 16'h001E, 16'd7, 9'h0, 16'h0, "scaled write");
		// the capture register takes the pulse one edge after the answer shows
		@(posedge core_clk);
		#1 chk("param write", 32'd28, last_pw);
		mb(0, 0, 16'h0028, 0, 9'h0, 16'h1234, "constant");
		mb(1, 0, 16'h0028, 16'h1, 9'h101, 16'h0, "denied write");
		mb(0, 0, 16'h0032, 0, 9'h0, 16'h1000, "newest sec");
		mb(0, 0, 16'h0033, 0, 9'h0, 16'h2000, "newest hhmm");
		mb(0, 0, 16'h0035, 0, 9'h0, 16'h2024, "newest year");
		mb(0, 0, 16'h0036, 0, 9'h0, 16'h0002, "newest type");
		mb(0, 0, 16'h003C, 0, 9'h0, 16'h8003, "second type");
		mb(0, 0, 16'h003D, 0, 9'h0, 16'hC001, "second code");
		mb(0, 0, 16'h003E, 0, 9'h102, 16'h0, "past events");
		mb(1, 0, 16'h0032, 16'h1, 9'h101, 16'h0, "event write");
		mb(0, 0, 16'h0046, 0, 9'h0, 16'h4142, "string word0");
		mb(0, 0, 16'h0047, 0, 9'h0, 16'h4300, "string word1");
		mb(0, 0, 16'h0048, 0, 9'h102, 16'h0, "string end");
		mb(1, 0, 16'h0050, 16'h1, 9'h0, 16'h0, "feature");
		@(posedge core_clk);
		#1 chk("feature code", 32'h9, {16'h0, fc});
		mb(0, 1, 16'h0005, 0, 9'h0, 16'h0190, "input read");
		mb(1, 1, 16'h0005, 16'h5, 9'h101, 16'h0, "input write");
		@(posedge core_clk);
		#1 chk("input no write", 32'd28, last_pw);
		mb(0, 0, 16'h0064, 0, 9'h0, 16'hA55A, "terminal in");
		mb(1, 0, 16'h0064, 16'h3C3C, 9'h0, 16'h0, "terminal write");
		chk("terminal out", 32'h3C3C, {16'h0, term_out});
		mb(1, 0, 16'h0002, 16'h0457, 9'h0, 16'h0, "ctrl write");
		mb(0, 0, 16'h0002, 0, 9'h0, 16'h0457, "ctrl read");
		cr(8'h04, 32'h0000_0457, "ctrl copy");
		mb(0, 0, 16'h000A, 0, 9'h0, 16'h0BEE, "status read");
		mb(1, 0, 16'h000A, 16'h1, 9'h101, 16'h0, "status write");
		mb(0, 0, 16'h0003, 0, 9'h102, 16'h0, "reserved");
		mb(0, 0, 16'hFFFF, 0, 9'h102, 16'h0, "top location");
		// own permissions on a writable parameter, so only the permission can refuse
		cw(8'h44, ent(6'b000110, MRM_SRC_PARAM, 16'h001E));
		mb(1, 0, 16'h001E, 16'd9, 9'h101, 16'h0, "perm wr denied");
		mb(0, 0, 16'h001E, 0, 9'h0, 16'd100, "perm rd allowed");
		cw(8'h44, ent(6'b001010, MRM_SRC_PARAM, 16'h001E));
		mb(0, 0, 16'h001E, 0, 9'h101, 16'h0, "perm rd denied");
		mb(1, 0, 16'h001E, 16'd2, 9'h0, 16'h0, "perm wr allowed");
		@(posedge core_clk);
		#1 chk("perm write", 32'd8, last_pw);
		cw(8'h5C, ent(6'b000001, MRM_SRC_TERM, 16'h0064));
		mb(0, 1, 16'h0064, 0, 9'h102, 16'h0, "input terminal");
		cr(8'h00, 32'h6, "irq status");
		chk("irq masked", 32'h0, {31'h0, irq});
		cw(8'h01, 32'h2);
		#1 chk("irq on", 32'h1, {31'h0, irq});
		cw(8'h00, 32'h2);
		#1 chk("irq cleared", 32'h0, {31'h0, irq});
		cw(8'h02, 32'h2);
		mb(1, 0, 16'h0014, 16'h4049, 9'h0, 16'h0, "wd kick");
		// two ms of MSC cycles each: expiry lands on the 2*MSC-th edge after the kick
		repeat (2 * MSC - 1) @(posedge core_clk);
		#1 chk("wd running", 32'h0, {31'h0, wd_expired});
		repeat (1) @(posedge core_clk);
		#1 chk("wd expired", 32'h1, {31'h0, wd_expired});
		cr(8'h00, 32'h5, "wd status");
		mb(1, 0, 16'h0014, 16'h4049, 9'h0, 16'h0, "wd rekick");
		#1 chk("wd restarted", 32'h0, {31'h0, wd_expired});
		stop_test();
	end
endmodule

bind mrm_mapper mrm_mapper_props u_props (.core_clk(core_clk), .rst(rst),
	.req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
	.rsp(rsp), .ctrl_word(ctrl_word), .param_wr(param_wr), .feat_pulse(feat_pulse));
